/* File: verilog/status_bank_pkg.sv */
// Package with command codes, bit positions, reset values and types of the status bank.
// Functional notes
// R1: Temperature reads as a 5-bit exponent fixed at minus two above an 11-bit signed mantissa.
// R2: Every unsupported status bit always reads zero and only the listed flags can ever be set.
// R3: Summary bit 15 is vout fault, 14 iout fault or warning, 13 input fault, 11 not power good.
// R4: Summary bits 6 to 1 are output off, vout OV, iout OC, input UV, temperature and comm fault.
// R5: The output voltage status byte reports overvoltage fault at bit 7 only.
// R6: The output current status byte reports overcurrent fault at bit 7 and warning at bit 5.
// R7: Input status bit 7 is overvoltage fault, bit 4 undervoltage fault, bit 3 off for low input.
// R8: Temperature status bit 7 is over-temperature fault and bit 6 its warning, the rest zero.
// R9: Communication status bit 7 is bad command, bit 6 bad data, bit 5 failed packet check.
// R10: Operation at code 01 supports only immediate on/off and margining that acts on faults.
// R11: Operation bits 6 and 3 to 0 are read-only at factory values; only 7, 5 and 4 take writes.
// R12: Operation bit 7 turns the output on or off at once; it resets to one and bits 3:2 to 10.
// R13: On/off config at code 02 shows the build polarity in writable bit 1; 4, 3, 2, 0 read one.
// R14: Operation bits 5:2 pick margining: 00XX off, 0110 low, 1010 high, both acting on faults.
// R15: Each detailed status flag stays set once detected until a clear-faults command or a reset.
// R16: Each summary bit except 11 and 6 reads as the OR of the matching detailed status flags.
package status_bank_pkg;
    localparam logic [7:0] CMD_OPERATION = 8'h01;
    localparam logic [7:0] CMD_ON_OFF_CFG = 8'h02;
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
    localparam logic [7:0] CMD_OUTPUT_VOLTAGE_STATUS = 8'h7a;
    localparam logic [7:0] CMD_OUTPUT_CURRENT_STATUS = 8'h7b;
    localparam logic [7:0] CMD_STATUS_INPUT = 8'h7c;
    localparam logic [7:0] CMD_STATUS_TEMP = 8'h7d;
    localparam logic [7:0] CMD_STATUS_COMM = 8'h7e;
    localparam logic [7:0] CMD_READ_TEMP = 8'h8d;
    localparam logic [7:0] OPERATION_RESET = 8'h88;
    localparam logic [7:0] OPERATION_WR_MASK = 8'hb0;
    localparam logic [7:0] ON_OFF_CFG_FIXED = 8'h1d;
    localparam int ON_OFF_POL_BIT = 1;
    localparam int OP_ON_BIT = 7;
    localparam logic [3:0] MARGIN_LOW_CODE = 4'h6;
    localparam logic [3:0] MARGIN_HIGH_CODE = 4'ha;
    localparam logic [4:0] TEMP_EXPONENT = 5'h1e;
    localparam int VOUT_OV_BIT = 7;
    localparam int IOUT_OC_FAULT_BIT = 7;
    localparam int IOUT_OC_WARN_BIT = 5;
    localparam int VIN_OV_BIT = 7;
    localparam int VIN_UV_BIT = 4;
    localparam int VIN_LOW_OFF_BIT = 3;
    localparam int OT_FAULT_BIT = 7;
    localparam int OT_WARN_BIT = 6;
    localparam int COMM_BAD_CMD_BIT = 7;
    localparam int COMM_BAD_DATA_BIT = 6;
    localparam int COMM_PEC_BIT = 5;
    localparam logic [7:0] VOUT_MASK = 8'h80;
    localparam logic [7:0] IOUT_MASK = 8'ha0;
    localparam logic [7:0] INPUT_MASK = 8'h98;
    localparam logic [7:0] TEMP_MASK = 8'hc0;
    localparam logic [7:0] COMM_MASK = 8'he0;
    localparam int SW_VOUT = 15;
    localparam int SW_IOUT = 14;
    localparam int SW_INPUT = 13;
    localparam int SW_PGOOD_N = 11;
    localparam int SW_OFF = 6;
    localparam int SW_VOUT_OV = 5;
    localparam int SW_IOUT_OC = 4;
    localparam int SW_VIN_UV = 3;
    localparam int SW_TEMP = 2;
    localparam int SW_COMM = 1;
    typedef enum logic [2:0] {
        MARGIN_OFF = 3'b001,
        MARGIN_LOW = 3'b010,
        MARGIN_HIGH = 3'b100
    } margin_t;
endpackage

/* File: verilog/fault_latch_if.sv */
// Interface carrying fault event pulses, clear request and latched flags.
`timescale 1ns/10ps
`default_nettype none
interface fault_latch_if;
    logic [7:0] set_vout;
    logic [7:0] set_iout;
    logic [7:0] set_input;
    logic [7:0] set_temp;
    logic [7:0] set_comm;
    logic clear;
    logic [7:0] vout;
    logic [7:0] iout;
    logic [7:0] input_st;
    logic [7:0] temp;
    logic [7:0] comm;
    modport bank (output set_vout, set_iout, set_input, set_temp, set_comm, clear,
        input vout, iout, input_st, temp, comm);
    modport latch (input set_vout, set_iout, set_input, set_temp, set_comm, clear,
        output vout, iout, input_st, temp, comm);
endinterface
`default_nettype wire

/* File: verilog/fault_latch.sv */
// Sticky detail status flags with clear-faults and masking of unsupported bits.
`timescale 1ns/10ps
`default_nettype none
module fault_latch (
    input wire logic clk,
    input wire logic sys_rst,
    fault_latch_if.latch fl
);
    typedef struct packed {
        logic [7:0] vout;
        logic [7:0] iout;
        logic [7:0] input_st;
        logic [7:0] temp;
        logic [7:0] comm;
    } latch_state_t;

    latch_state_t st_r;
    latch_state_t st_nxt;

    // A new event wins over a clear in the same cycle so it is never lost.
    always_comb begin
        st_nxt = fl.clear ? '0 : st_r; // R15
        st_nxt.vout = (st_nxt.vout | fl.set_vout) & status_bank_pkg::VOUT_MASK; // R5 R2
        st_nxt.iout = (st_nxt.iout | fl.set_iout) & status_bank_pkg::IOUT_MASK; // R6 R2
        st_nxt.input_st = (st_nxt.input_st | fl.set_input) & status_bank_pkg::INPUT_MASK; // R7
        st_nxt.temp = (st_nxt.temp | fl.set_temp) & status_bank_pkg::TEMP_MASK; // R8
        st_nxt.comm = (st_nxt.comm | fl.set_comm) & status_bank_pkg::COMM_MASK; // R9
    end

    // Flags hold until cleared or reset.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r <= '0; // R15
        end else begin
            st_r <= st_nxt;
        end
    end

    assign fl.vout = st_r.vout;
    assign fl.iout = st_r.iout;
    assign fl.input_st = st_r.input_st;
    assign fl.temp = st_r.temp;
    assign fl.comm = st_r.comm;
endmodule // fault_latch
`default_nettype wire

/* File: verilog/status_bank.sv */
// Status and control register bank behind the power module's command port.
`timescale 1ns/10ps
`default_nettype none
module status_bank (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic build_polarity,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] cmd_wdata,
    output logic [15:0] cmd_rdata,
    output logic cmd_rvalid,
    output logic cmd_unsupported,
    input wire logic [10:0] temp_mantissa,
    input wire logic power_good,
    input wire logic ev_vout_ov,
    input wire logic ev_iout_oc_fault,
    input wire logic ev_iout_oc_warn,
    input wire logic ev_vin_ov,
    input wire logic ev_vin_uv,
    input wire logic ev_vin_low_off,
    input wire logic ev_ot_fault,
    input wire logic ev_ot_warn,
    input wire logic ev_bad_data,
    input wire logic ev_pec_fail,
    output logic output_enable,
    output logic [2:0] margin_select
);
    typedef struct packed {
        logic [7:0] operation;
        logic [7:0] on_off_cfg;
        logic pol_loaded;
        logic [15:0] rdata;
        logic rvalid;
        logic unsupported;
        logic out_en;
        status_bank_pkg::margin_t margin;
    } bank_state_t;

    bank_state_t st_r;
    bank_state_t st_nxt;
    fault_latch_if fl ();
    logic [15:0] status_word;
    logic bad_cmd;

    // Decodes the margin field of the operation byte.
    function automatic status_bank_pkg::margin_t margin_decode(input logic [7:0] op);
        status_bank_pkg::margin_t m;
        m = status_bank_pkg::MARGIN_OFF;
        if (op[5:2] == status_bank_pkg::MARGIN_LOW_CODE) begin
            m = status_bank_pkg::MARGIN_LOW; // R14
        end else if (op[5:2] == status_bank_pkg::MARGIN_HIGH_CODE) begin
            m = status_bank_pkg::MARGIN_HIGH; // R14
        end
        return m;
    endfunction

    // True when the code names a command this bank answers.
    function automatic logic known_cmd(input logic [7:0] c);
        logic k;
        k = 1'b0;
        case (c)
            status_bank_pkg::CMD_OPERATION, status_bank_pkg::CMD_ON_OFF_CFG,
            status_bank_pkg::CMD_CLEAR_FAULTS, status_bank_pkg::CMD_STATUS_WORD,
            status_bank_pkg::CMD_OUTPUT_VOLTAGE_STATUS, status_bank_pkg::CMD_OUTPUT_CURRENT_STATUS,
            status_bank_pkg::CMD_STATUS_INPUT, status_bank_pkg::CMD_STATUS_TEMP,
            status_bank_pkg::CMD_STATUS_COMM, status_bank_pkg::CMD_READ_TEMP: k = 1'b1;
            default: k = 1'b0;
        endcase
        return k;
    endfunction

    fault_latch u_fault_latch (
        .clk(clk),
        .sys_rst(sys_rst),
        .fl(fl)
    );

    // An unknown code, a read of a write-only command or a write to a
    // read-only one flags a bad command.
    always_comb begin
        bad_cmd = 1'b0;
        if ((cmd_wr || cmd_rd) && !known_cmd(cmd_code)) begin
            bad_cmd = 1'b1;
        end else if (cmd_wr && cmd_code != status_bank_pkg::CMD_OPERATION
                && cmd_code != status_bank_pkg::CMD_ON_OFF_CFG
                && cmd_code != status_bank_pkg::CMD_CLEAR_FAULTS) begin
            bad_cmd = 1'b1;
        end else if (cmd_rd && cmd_code == status_bank_pkg::CMD_CLEAR_FAULTS) begin
            bad_cmd = 1'b1;
        end
    end

    // Event pulses into the sticky detail flags.
    always_comb begin
        fl.set_vout = '0;
        fl.set_vout[status_bank_pkg::VOUT_OV_BIT] = ev_vout_ov;
        fl.set_iout = '0;
        fl.set_iout[status_bank_pkg::IOUT_OC_FAULT_BIT] = ev_iout_oc_fault;
        fl.set_iout[status_bank_pkg::IOUT_OC_WARN_BIT] = ev_iout_oc_warn;
        fl.set_input = '0;
        fl.set_input[status_bank_pkg::VIN_OV_BIT] = ev_vin_ov;
        fl.set_input[status_bank_pkg::VIN_UV_BIT] = ev_vin_uv;
        fl.set_input[status_bank_pkg::VIN_LOW_OFF_BIT] = ev_vin_low_off;
        fl.set_temp = '0;
        fl.set_temp[status_bank_pkg::OT_FAULT_BIT] = ev_ot_fault;
        fl.set_temp[status_bank_pkg::OT_WARN_BIT] = ev_ot_warn;
        fl.set_comm = '0;
        fl.set_comm[status_bank_pkg::COMM_BAD_CMD_BIT] = bad_cmd; // R9
        fl.set_comm[status_bank_pkg::COMM_BAD_DATA_BIT] = ev_bad_data; // R9
        fl.set_comm[status_bank_pkg::COMM_PEC_BIT] = ev_pec_fail; // R9
        fl.clear = cmd_wr && cmd_code == status_bank_pkg::CMD_CLEAR_FAULTS; // R15
    end

    // Summary word is built from the detail flags, power_good and the output enable, so its
    // fault bits always agree with the flags; unsupported positions stay at zero.
    always_comb begin
        status_word = '0; // R2
        status_word[status_bank_pkg::SW_VOUT] = |fl.vout; // R3 R16
        status_word[status_bank_pkg::SW_IOUT] = |fl.iout; // R3 R16
        status_word[status_bank_pkg::SW_INPUT] = |fl.input_st; // R3 R16
        status_word[status_bank_pkg::SW_PGOOD_N] = ~power_good; // R3
        status_word[status_bank_pkg::SW_OFF] = ~st_r.out_en; // R4
        status_word[status_bank_pkg::SW_VOUT_OV] = fl.vout[status_bank_pkg::VOUT_OV_BIT]; // R4
        status_word[status_bank_pkg::SW_IOUT_OC] =
            fl.iout[status_bank_pkg::IOUT_OC_FAULT_BIT]; // R4
        status_word[status_bank_pkg::SW_VIN_UV] = fl.input_st[status_bank_pkg::VIN_UV_BIT]; // R4
        status_word[status_bank_pkg::SW_TEMP] = |fl.temp; // R4 R16
        status_word[status_bank_pkg::SW_COMM] = |fl.comm; // R4 R16
    end

    // Register writes, read data capture and control outputs.
    always_comb begin
        st_nxt = st_r;
        st_nxt.rvalid = 1'b0;
        st_nxt.unsupported = bad_cmd;
        // Polarity strap is caught on the first clocked cycle after reset.
        if (!st_r.pol_loaded) begin
            st_nxt.on_off_cfg[status_bank_pkg::ON_OFF_POL_BIT] = build_polarity; // R13
            st_nxt.pol_loaded = 1'b1;
        end
        if (cmd_wr && cmd_code == status_bank_pkg::CMD_OPERATION) begin
            st_nxt.operation = (cmd_wdata & status_bank_pkg::OPERATION_WR_MASK)
                | (st_r.operation & ~status_bank_pkg::OPERATION_WR_MASK); // R11 R10
        end
        if (cmd_wr && cmd_code == status_bank_pkg::CMD_ON_OFF_CFG) begin
            st_nxt.on_off_cfg[status_bank_pkg::ON_OFF_POL_BIT] =
                cmd_wdata[status_bank_pkg::ON_OFF_POL_BIT]; // R13
        end
        st_nxt.out_en = st_nxt.operation[status_bank_pkg::OP_ON_BIT]; // R12
        st_nxt.margin = margin_decode(st_nxt.operation); // R14 R10
        if (cmd_rd && !bad_cmd) begin
            st_nxt.rvalid = 1'b1;
            case (cmd_code)
                status_bank_pkg::CMD_OPERATION: st_nxt.rdata = {8'h00, st_r.operation};
                status_bank_pkg::CMD_ON_OFF_CFG: st_nxt.rdata = {8'h00, st_r.on_off_cfg};
                status_bank_pkg::CMD_STATUS_WORD: st_nxt.rdata = status_word;
                status_bank_pkg::CMD_OUTPUT_VOLTAGE_STATUS: st_nxt.rdata = {8'h00, fl.vout};
                status_bank_pkg::CMD_OUTPUT_CURRENT_STATUS: st_nxt.rdata = {8'h00, fl.iout};
                status_bank_pkg::CMD_STATUS_INPUT: st_nxt.rdata = {8'h00, fl.input_st};
                status_bank_pkg::CMD_STATUS_TEMP: st_nxt.rdata = {8'h00, fl.temp};
                status_bank_pkg::CMD_STATUS_COMM: st_nxt.rdata = {8'h00, fl.comm};
                status_bank_pkg::CMD_READ_TEMP:
                    st_nxt.rdata = {status_bank_pkg::TEMP_EXPONENT, temp_mantissa}; // R1
                default: st_nxt.rdata = '0;
            endcase
        end
    end

    // Reset puts the output on with margining off.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r.operation <= status_bank_pkg::OPERATION_RESET; // R12
            st_r.on_off_cfg <= status_bank_pkg::ON_OFF_CFG_FIXED; // R13
            st_r.pol_loaded <= 1'b0;
            st_r.rdata <= 16'h0000;
            st_r.rvalid <= 1'b0;
            st_r.unsupported <= 1'b0;
            st_r.out_en <= 1'b1;
            st_r.margin <= status_bank_pkg::MARGIN_OFF;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cmd_rdata = st_r.rdata;
    assign cmd_rvalid = st_r.rvalid;
    assign cmd_unsupported = st_r.unsupported;
    assign output_enable = st_r.out_en;
    assign margin_select = st_r.margin;
endmodule // status_bank
`default_nettype wire

/* File: bench/status_bank_properties.sv */
// Checker of the status bank port behaviour, bound to the bank.
`timescale 1ns/10ps
`default_nettype none
module status_bank_properties (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] cmd_wdata,
    input wire logic [15:0] cmd_rdata,
    input wire logic cmd_rvalid,
    input wire logic cmd_unsupported,
    input wire logic [10:0] temp_mantissa,
    input wire logic power_good,
    input wire logic output_enable,
    input wire logic [2:0] margin_select
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Decoded requests; every answer is judged one cycle after the taking edge.
    wire rd_word = cmd_rd && cmd_code == 8'h79;
    wire op_wr = cmd_wr && cmd_code == 8'h01;
    wire [1:0] mg = cmd_wdata[5:4];
    rst_values_a: assert property (
        $fell(sys_rst) |-> output_enable && margin_select == 3'b001)
        else $error("bad reset state");
    temp_format_a: assert property (
        cmd_rd && cmd_code == 8'h8d |=> cmd_rvalid && cmd_rdata == {5'h1e, $past(temp_mantissa)})
        else $error("temperature format wrong");
    word_reserved_a: assert property (
        rd_word |=> cmd_rvalid && (cmd_rdata & 16'h1781) == 16'h0000)
        else $error("reserved bit set");
    pgood_bit_a: assert property (
        rd_word |=> cmd_rdata[11] == !$past(power_good)) else $error("power good bit wrong");
    off_bit_a: assert property (
        rd_word |=> cmd_rdata[6] == !$past(output_enable)) else $error("off bit wrong");
    out_enable_a: assert property (
        op_wr |=> output_enable == $past(cmd_wdata[7])) else $error("output enable wrong");
    // The pattern with both margin bits set is not a listed selection, so it is left out.
    margin_sel_a: assert property (
        op_wr && mg != 2'b11 |=> margin_select == {$past(mg) == 2'b10, $past(mg) == 2'b01,
        $past(mg) == 2'b00}) else $error("margin select wrong");
    refuse_cmd_a: assert property (
        cmd_rd && cmd_code == 8'h03 |=> cmd_unsupported && !cmd_rvalid) else $error("not refused");
    cover property (cmd_unsupported);
    cover property (margin_select == 3'b100);
    cover property (cmd_rvalid && cmd_rdata[15]);
endmodule // status_bank_properties
bind status_bank status_bank_properties chk (.*);
`default_nettype wire

/* File: bench/host_model.sv */
// Host controller model issuing one command at a time to the bank.
`timescale 1ns/10ps
`default_nettype none
module host_model (
    input wire logic clk,
    output logic cmd_wr,
    output logic cmd_rd,
    output logic [7:0] cmd_code,
    output logic [7:0] cmd_wdata,
    input wire logic [15:0] cmd_rdata,
    input wire logic cmd_rvalid,
    input wire logic cmd_unsupported
);
    // Idle bus at time zero.
    initial begin
        {cmd_wr, cmd_rd, cmd_code, cmd_wdata} = 18'h00000;
    end
    // Strobe raised after an edge, held over the taking edge, answer caught one cycle on.
    // Released lines are inverted so a stale code never passes for a held one.
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] data,
            output logic [15:0] rdata, output logic ok, output logic bad);
        @(posedge clk);
        #1;
        {cmd_wr, cmd_rd, cmd_code, cmd_wdata} = {wr, !wr, code, data};
        @(posedge clk);
        #1;
        {rdata, ok, bad} = {cmd_rdata, cmd_rvalid, cmd_unsupported};
        {cmd_wr, cmd_rd, cmd_code, cmd_wdata} = {2'b00, ~code, ~data};
    endtask
endmodule // host_model
`default_nettype wire

/* File: bench/status_bank_tb.sv */
// Self-checking bench for the status and control register bank.
`timescale 1ns/10ps
`default_nettype none
module status_bank_tb;
    logic clk, sys_rst, build_polarity, power_good, ok, bad;
    logic [10:0] temp_mantissa;
    logic [9:0] ev;
    logic [15:0] rd;
    wire cmd_wr, cmd_rd, cmd_rvalid, cmd_unsupported, output_enable;
    wire [7:0] cmd_code, cmd_wdata;
    wire [15:0] cmd_rdata;
    wire [2:0] margin_select;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [7:0] ev_code [10] = '{8'h7a, 8'h7b, 8'h7b, 8'h7c, 8'h7c, 8'h7c, 8'h7d, 8'h7d,
        8'h7e, 8'h7e};
    logic [7:0] ev_flag [10] = '{8'h80, 8'h80, 8'h20, 8'h80, 8'h10, 8'h08, 8'h80, 8'h40,
        8'h40, 8'h20};
    logic [15:0] ev_word [10] = '{16'h8020, 16'h4010, 16'h4000, 16'h2000, 16'h2008, 16'h2000,
        16'h0004, 16'h0004, 16'h0002, 16'h0002};
    host_model host (.clk(clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
        .cmd_unsupported(cmd_unsupported));
    status_bank dut (.clk(clk), .sys_rst(sys_rst), .build_polarity(build_polarity),
        .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid), .cmd_unsupported(cmd_unsupported),
        .temp_mantissa(temp_mantissa), .power_good(power_good), .ev_vout_ov(ev[0]),
        .ev_iout_oc_fault(ev[1]), .ev_iout_oc_warn(ev[2]), .ev_vin_ov(ev[3]), .ev_vin_uv(ev[4]),
        .ev_vin_low_off(ev[5]), .ev_ot_fault(ev[6]), .ev_ot_warn(ev[7]), .ev_bad_data(ev[8]),
        .ev_pec_fail(ev[9]), .output_enable(output_enable), .margin_select(margin_select));
    // Free-running 25 MHz clock.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Hang guard; the whole run needs well under a thousand cycles.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic stop_test;
        if (miscompares == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // A read must be answered with a valid pulse and the expected word.
    task automatic rd_chk(input logic [7:0] code, input logic [15:0] exp);
        host.xfer(1'b0, code, 8'h00, rd, ok, bad);
        chk({15'h0000, ok}, 16'h0001);
        chk(rd, exp);
    endtask
    task automatic wr(input logic [7:0] code, input logic [7:0] data);
        host.xfer(1'b1, code, data, rd, ok, bad);
    endtask
    task automatic t_reset;
        rd_chk(8'h01, 16'h0088);
        rd_chk(8'h02, 16'h001f);
        rd_chk(8'h79, 16'h0000);
        for (int i = 8'h7a; i <= 8'h7e; i++) begin
            rd_chk(8'(i), 16'h0000);
        end
    endtask
    // Only listed margin patterns are written; read-only bits are set in the data on purpose.
    task automatic t_oper;
        logic [7:0] wd [4] = '{8'h6f, 8'h90, 8'h80, 8'h00};
        logic [7:0] op [4] = '{8'h28, 8'h98, 8'h88, 8'h08};
        logic [2:0] mg [4] = '{3'b100, 3'b010, 3'b001, 3'b001};
        for (int i = 0; i < 4; i++) begin
            wr(8'h01, wd[i]);
            chk({13'h0000, margin_select}, {13'h0000, mg[i]});
            chk({15'h0000, output_enable}, {15'h0000, wd[i][7]});
            rd_chk(8'h01, {8'h00, op[i]});
        end
        rd_chk(8'h79, 16'h0040);
        wr(8'h01, 8'h80);
        wr(8'h02, 8'h00);
        rd_chk(8'h02, 16'h001d);
    endtask
    // One pulse per event; the flag must survive two reads and fall only on clear faults.
    task automatic t_faults;
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            #1;
            ev[i] = 1'b1;
            @(posedge clk);
            #1;
            ev[i] = 1'b0;
            rd_chk(ev_code[i], {8'h00, ev_flag[i]});
            rd_chk(ev_code[i], {8'h00, ev_flag[i]});
            rd_chk(8'h79, ev_word[i]);
            wr(8'h03, 8'h00);
            rd_chk(ev_code[i], 16'h0000);
        end
    endtask
    task automatic t_refuse;
        logic [7:0] bc [3] = '{8'h03, 8'hff, 8'h79};
        for (int i = 0; i < 3; i++) begin
            host.xfer(i == 2, bc[i], 8'h00, rd, ok, bad);
            chk({14'h0000, ok, bad}, 16'h0001);
        end
        rd_chk(8'h7e, 16'h0080);
        rd_chk(8'h79, 16'h0002);
        // An event still present at the clear must outlive it, or a fault could go unseen.
        ev[9] = 1'b1;
        wr(8'h03, 8'h00);
        ev[9] = 1'b0;
        rd_chk(8'h7e, 16'h0020);
        wr(8'h03, 8'h00);
    endtask
    // Exponent minus two in five bits is 5'h1e.
    task automatic t_live;
        logic [10:0] m [2] = '{11'h7ff, 11'h123};
        for (int i = 0; i < 2; i++) begin
            temp_mantissa = m[i];
            rd_chk(8'h8d, {5'h1e, m[i]});
        end
        power_good = 1'b0;
        rd_chk(8'h79, 16'h0800);
        power_good = 1'b1;
    endtask
    // Main sequence, ending with a mid-run reset under the other build polarity.
    initial begin
        {sys_rst, build_polarity, power_good, temp_mantissa, ev} = {3'b111, 11'h000, 10'h000};
        repeat (4) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        t_reset();
        t_oper();
        t_faults();
        t_refuse();
        t_live();
        // Move every control field off its reset value so the reset has to restore it.
        wr(8'h01, 8'h10);
        wr(8'h02, 8'h02);
        {sys_rst, build_polarity} = 2'b10;
        @(posedge clk);
        #1;
        sys_rst = 1'b0;
        chk({13'h0000, margin_select}, 16'h0001);
        chk({15'h0000, output_enable}, 16'h0001);
        rd_chk(8'h02, 16'h001d);
        rd_chk(8'h01, 16'h0088);
        stop_test();
    end
endmodule // status_bank_tb
`default_nettype wire
